// ===== logic/pms_pkg.sv
// package: offsets, field positions, reset values and carriers of the mode status block
package pms_pkg;
    // apb byte offsets
    localparam logic [11:0] PMS_OFS_MODE_STATUS = 12'h000;
    localparam logic [11:0] PMS_OFS_VECTOR_INFO = 12'h004;
    localparam logic [11:0] PMS_OFS_EXT_ADDRESS = 12'h008;
    // processor_mode_status field positions
    localparam int PMS_PTR_MSB   = 15;
    localparam int PMS_PTR_LSB   = 7;
    localparam int PMS_ROM_SEL   = 6;
    localparam int PMS_RAM_OVL   = 5;
    localparam int PMS_ADDR_VIS  = 4;
    localparam int PMS_DATA_ROM  = 3;
    localparam int PMS_CLK_DIS   = 2;
    localparam int PMS_MUL_SAT   = 1;
    localparam int PMS_STORE_SAT = 0;
    // widths and reset values
    localparam int PMS_PTR_W     = 9;
    localparam int PMS_OFS_W     = 7;
    localparam int PMS_VNUM_W    = 5;
    localparam int PMS_SLOT_LOG2 = 2;
    localparam logic [8:0]  PMS_PTR_RESET    = 9'h1FF;
    localparam logic [6:0]  PMS_LOW_RESET    = 7'h00;
    localparam logic [15:0] PMS_RESET_VECTOR = 16'hFF80;
    localparam logic [15:0] PMS_PAGE0_LAST   = 16'h007F;

    typedef struct packed {
        logic                  valid;
        logic                  hw_reset;
        logic [PMS_VNUM_W-1:0] number;
    } pms_vector_req_s;

    typedef struct packed {
        logic rom_in_program;
        logic ram_overlay;
        logic data_space_rom_map;
        logic multiply_saturate;
        logic store_saturate;
    } pms_mode_s;
endpackage : pms_pkg

// ===== logic/pms_mode_status.sv
// processor mode status register, vector address generation and related pin control
// Overview of operation
// - on reset, interrupt or trap, program counter loads the vector address.
// - each vector slot spans four program words.
// - after device reset all vectors sit in page starting at FF80h.
// - non-reset vectors taken after a pointer write come from the new 128-word page.
// - hardware reset sets pointer to all ones; reset vector always in page FF80h, slot from vector number.
// - pointer is read/write bits 15 down to 7, reset value 1FFh.
// - the software reset instruction leaves the pointer unchanged.
// - rom select bit 6: 0 puts on-chip rom in program space, 1 removes.
// - rom select captures strap at reset only; software may change it.
// - ram overlay bit 5 maps ram into program space except 0h to 7Fh.
// - with address visibility clear, external address holds last driven address.
// - with address visibility set, internal program address drives external pins.
// - data rom bit 3 maps on-chip rom into data space when set.
// - clock output disable bit 2 holds clock output pin high.
// - multiply saturate applies only with overflow and fractional mode set.
// - store saturate bit 0 enables saturation of stored accumulator data.
module pms_mode_status (
    // clock, reset, enable
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_rstn,
    input  wire logic                    i_ce,
    // apb slave
    input  wire logic                    i_psel,
    input  wire logic                    i_penable,
    input  wire logic                    i_pwrite,
    input  wire logic [11:0]             i_paddr,
    input  wire logic [31:0]             i_pwdata,
    output logic                         o_pready,
    output logic [31:0]                  o_prdata,
    output logic                         o_pslverr,
    // strap and core sequencing
    input  wire logic                    i_rom_select_strap,
    input  wire pms_pkg::pms_vector_req_s i_vector_req,
    input  wire logic                    i_soft_reset,
    input  wire logic                    i_overflow_mode,
    input  wire logic                    i_fractional_mode,
    // program address and external bus
    input  wire logic [15:0]             i_prog_addr,
    input  wire logic                    i_ext_access,
    input  wire logic [15:0]             i_ext_addr,
    // to core
    output logic                         o_pc_load,
    output logic [15:0]                  o_program_counter,
    output pms_pkg::pms_mode_s           o_mode,
    output logic                         o_ram_overlay_hit,
    // pins
    output logic [15:0]                  o_ext_address,
    output logic                         o_clock_output_pin
);
    import pms_pkg::*;

    // reset release
    logic        rst_meta_n;
    logic        rst_n;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else if (i_ce) begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // register state
    logic [PMS_PTR_W-1:0] vector_page_pointer;
    logic                 rom_select;
    logic                 ram_overlay;
    logic                 address_visibility;
    logic                 data_space_rom_map;
    logic                 clock_output_disable;
    logic                 multiply_saturate;
    logic                 store_saturate;
    logic                 strap_pending;
    logic [15:0]          last_vector;

    // apb decode
    wire        setup_phase = i_psel && !i_penable;
    wire        wr_commit   = i_psel && i_penable && o_pready && i_pwrite;
    wire        hit_mode    = (i_paddr == PMS_OFS_MODE_STATUS);
    wire        hit_vinfo   = (i_paddr == PMS_OFS_VECTOR_INFO);
    wire        hit_ext     = (i_paddr == PMS_OFS_EXT_ADDRESS);
    wire        mapped      = hit_mode || hit_vinfo || hit_ext;
    wire        wr_mode     = wr_commit && hit_mode;

    wire [15:0] mode_word = {vector_page_pointer, rom_select, ram_overlay,
                             address_visibility, data_space_rom_map,
                             clock_output_disable, multiply_saturate,
                             store_saturate};

    wire [31:0] read_mux = hit_mode  ? {16'h0000, mode_word} :
                           hit_vinfo ? {16'h0000, last_vector} :
                           hit_ext   ? {16'h0000, o_ext_address} :
                                       32'h0000_0000;

    // vector address formation
    function automatic logic [15:0] vector_address(input logic [PMS_PTR_W-1:0]  page,
                                                   input logic [PMS_VNUM_W-1:0] num);
        vector_address = {page, num, {PMS_SLOT_LOG2{1'b0}}};
    endfunction : vector_address

    wire [PMS_PTR_W-1:0] vec_page   = i_vector_req.hw_reset ? PMS_PTR_RESET
                                                            : vector_page_pointer;
    wire [15:0]          next_vector = vector_address(vec_page, i_vector_req.number);

    // apb slave: one wait-free access phase, registered response
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (i_ce) begin
            o_pready  <= setup_phase;
            o_prdata  <= setup_phase && !i_pwrite ? read_mux : 32'h0000_0000;
            o_pslverr <= setup_phase && !mapped;
        end
    end

    // vector page pointer: only hardware reset and software touch it
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            vector_page_pointer <= PMS_PTR_RESET;
        end else if (i_ce && wr_mode) begin
            vector_page_pointer <= i_pwdata[PMS_PTR_MSB:PMS_PTR_LSB];
        end
    end

    // rom select: strap captured once after reset release, then software owned
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_pending <= 1'b1;
            rom_select    <= 1'b0;
        end else if (i_ce) begin
            strap_pending <= 1'b0;
            if (strap_pending) begin
                rom_select <= i_rom_select_strap;
            end else if (wr_mode) begin
                rom_select <= i_pwdata[PMS_ROM_SEL];
            end
        end
    end

    // remaining mode bits: writable, restored by the reset instruction
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {ram_overlay, address_visibility, data_space_rom_map, clock_output_disable,
             multiply_saturate, store_saturate} <= PMS_LOW_RESET[5:0];
        end else if (i_ce) begin
            if (wr_mode) begin
                ram_overlay          <= i_pwdata[PMS_RAM_OVL];
                address_visibility   <= i_pwdata[PMS_ADDR_VIS];
                data_space_rom_map   <= i_pwdata[PMS_DATA_ROM];
                clock_output_disable <= i_pwdata[PMS_CLK_DIS];
                multiply_saturate    <= i_pwdata[PMS_MUL_SAT];
                store_saturate       <= i_pwdata[PMS_STORE_SAT];
            end else if (i_soft_reset) begin
                {ram_overlay, address_visibility, data_space_rom_map, clock_output_disable,
                 multiply_saturate, store_saturate} <= PMS_LOW_RESET[5:0];
            end
        end
    end

    // program counter load on vector take
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_pc_load         <= 1'b0;
            o_program_counter <= PMS_RESET_VECTOR;
            last_vector       <= PMS_RESET_VECTOR;
        end else if (i_ce) begin
            o_pc_load <= i_vector_req.valid;
            if (i_vector_req.valid) begin
                o_program_counter <= next_vector;
                last_vector       <= next_vector;
            end
        end
    end

    // mode outputs to the memory decoders and datapath
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_mode            <= '0;
            o_ram_overlay_hit <= 1'b0;
        end else if (i_ce) begin
            o_mode.rom_in_program     <= !rom_select;
            o_mode.ram_overlay        <= ram_overlay;
            o_mode.data_space_rom_map <= data_space_rom_map;
            o_mode.multiply_saturate  <= multiply_saturate && i_overflow_mode
                                         && i_fractional_mode;
            o_mode.store_saturate     <= store_saturate;
            o_ram_overlay_hit         <= ram_overlay && (i_prog_addr > PMS_PAGE0_LAST);
        end
    end

    // external address pins
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_ext_address <= 16'h0000;
        end else if (i_ce) begin
            if (address_visibility) begin
                o_ext_address <= i_prog_addr;
            end else if (i_ext_access) begin
                o_ext_address <= i_ext_addr;
            end
        end
    end

    // clock output pin, half the system clock rate
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_clock_output_pin <= 1'b0;
        end else if (i_ce) begin
            o_clock_output_pin <= clock_output_disable ? 1'b1 : !o_clock_output_pin;
        end
    end
endmodule : pms_mode_status

// ===== tb/pms_mode_status_chk.sv
// checker: port assertions of the mode status block
module pms_mode_status_chk (
    // clock and reset
    input wire logic                     i_sys_clk,
    input wire logic                     i_rstn,
    // apb
    input wire logic                     i_psel,
    input wire logic                     i_penable,
    input wire logic [11:0]              i_paddr,
    input wire logic                     o_pready,
    input wire logic                     o_pslverr,
    // core and pins
    input wire pms_pkg::pms_vector_req_s i_vector_req,
    input wire logic [15:0]              i_prog_addr,
    input wire logic                     o_pc_load,
    input wire logic [15:0]              o_program_counter,
    input wire logic                     o_ram_overlay_hit,
    input wire logic                     o_clock_output_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    import pms_pkg::*;
    logic mapped;
    always_ff @(posedge i_sys_clk) begin
        mapped <= i_paddr inside {PMS_OFS_MODE_STATUS, PMS_OFS_VECTOR_INFO,
                                  PMS_OFS_EXT_ADDRESS};
    end
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    chk_apb_answer: assert property (s_setup |=> o_pready)
        else $error("setup without answer");
    chk_bad_addr: assert property (o_pready |-> o_pslverr != mapped)
        else $error("error flag wrong");
    chk_pc_pulse: assert property (o_pc_load == $past(i_vector_req.valid))
        else $error("pc load pulse wrong");
    chk_pc_hold: assert property (!i_vector_req.valid |=> $stable(o_program_counter))
        else $error("pc moved without take");
    chk_hw_vector:
        assert property (i_vector_req.valid && i_vector_req.hw_reset
                         |=> o_pc_load && o_program_counter[15:7] == PMS_PTR_RESET)
        else $error("hw reset vector page");
    chk_slot_addr:
        assert property (i_vector_req.valid |=> o_program_counter[6:0] == {$past(i_vector_req.number), 2'b00})
        else $error("vector slot wrong");
    chk_clk_rise: assert property ($fell(o_clock_output_pin) |=> o_clock_output_pin)
        else $error("clock pin stuck low");
    chk_page0_hit: assert property (o_ram_overlay_hit |-> $past(i_prog_addr) > 16'h007F)
        else $error("overlay hit in page 0");
endmodule : pms_mode_status_chk

bind pms_mode_status pms_mode_status_chk u_chk (
    .i_sys_clk, .i_rstn, .i_psel, .i_penable, .i_paddr, .o_pready, .o_pslverr,
    .i_vector_req, .i_prog_addr, .o_pc_load, .o_program_counter,
    .o_ram_overlay_hit, .o_clock_output_pin
);

// ===== tb/pms_core_model.sv
// partner: core sequencing side, vector takes and mode levels
module pms_core_model (
    // clock
    input  wire logic                i_sys_clk,
    // to block
    output pms_pkg::pms_vector_req_s o_vector_req,
    output logic                     o_soft_reset,
    output logic                     o_overflow_mode,
    output logic                     o_fractional_mode,
    output logic [15:0]              o_prog_addr,
    output logic                     o_ext_access,
    output logic [15:0]              o_ext_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    import pms_pkg::*;
    initial {o_vector_req, o_soft_reset, o_overflow_mode, o_fractional_mode} = '0;
    initial {o_prog_addr, o_ext_access, o_ext_addr} = '0;
    // one-cycle take of a vector
    task automatic take(input logic hw, input logic [4:0] num);
        @(posedge i_sys_clk);
        o_vector_req <= '{valid: 1'b1, hw_reset: hw, number: num};
        @(posedge i_sys_clk);
        o_vector_req <= '0;
    endtask : take
    // reset instruction pulse
    task automatic soft_reset();
        @(posedge i_sys_clk);
        o_soft_reset <= 1'b1;
        @(posedge i_sys_clk);
        o_soft_reset <= 1'b0;
    endtask : soft_reset
    // external access, address lines scrambled once released
    task automatic ext(input logic [15:0] a);
        @(posedge i_sys_clk);
        o_ext_access <= 1'b1;
        o_ext_addr <= a;
        @(posedge i_sys_clk);
        o_ext_access <= 1'b0;
        o_ext_addr <= ~a;
    endtask : ext
    // arithmetic mode levels and program address
    task automatic levels(input logic ovf, input logic frac, input logic [15:0] pa);
        @(posedge i_sys_clk);
        o_overflow_mode <= ovf;
        o_fractional_mode <= frac;
        o_prog_addr <= pa;
    endtask : levels
endmodule : pms_core_model

// ===== tb/test_processor_mode_status_vectors.sv
// testbench: registers, vector takes and pins of the mode status block
module test_processor_mode_status_vectors;
    timeunit 1ns;
    timeprecision 100ps;
    import pms_pkg::*;
    logic            i_sys_clk = 1'b0;
    logic            i_rstn = 1'b0;
    logic            i_rom_select_strap = 1'b1;
    logic            i_psel = 1'b0;
    logic            i_penable = 1'b0;
    logic            i_pwrite = 1'b0;
    logic [11:0]     i_paddr = '0;
    logic [31:0]     i_pwdata = '0;
    logic [31:0]     o_prdata;
    logic            o_pready, o_pslverr, o_pc_load, o_ram_overlay_hit, o_clock_output_pin;
    logic [15:0]     o_program_counter, o_ext_address, i_prog_addr, i_ext_addr;
    logic            i_soft_reset, i_overflow_mode, i_fractional_mode, i_ext_access;
    pms_vector_req_s i_vector_req;
    pms_mode_s       o_mode;
    int              err_total = 0;
    int              n_checks = 0;
    always #2 i_sys_clk = ~i_sys_clk;
    pms_mode_status uut (.i_sys_clk, .i_rstn, .i_ce(1'b1), .i_psel, .i_penable, .i_pwrite,
        .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_rom_select_strap,
        .i_vector_req, .i_soft_reset, .i_overflow_mode, .i_fractional_mode, .i_prog_addr,
        .i_ext_access, .i_ext_addr, .o_pc_load, .o_program_counter, .o_mode,
        .o_ram_overlay_hit, .o_ext_address, .o_clock_output_pin);
    pms_core_model core (.i_sys_clk, .o_vector_req(i_vector_req), .o_soft_reset(i_soft_reset),
        .o_overflow_mode(i_overflow_mode), .o_fractional_mode(i_fractional_mode),
        .o_prog_addr(i_prog_addr), .o_ext_access(i_ext_access), .o_ext_addr(i_ext_addr));
    task automatic wrap_up();
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n = 0;
        @(posedge i_sys_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        if (o_pready !== 1'b1) begin
            err_total++;
            wrap_up();
        end
    endtask : apb
    initial begin
        logic [31:0] rd;
        logic        er;
        repeat (10) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
        i_rom_select_strap <= 1'b0;
        apb(1'b0, 12'h000, '0, rd, er);
        chk(rd, 32'h0000FFC0);
        core.take(1'b0, 5'd3);
        @(negedge i_sys_clk);
        chk({16'h0, o_program_counter}, 32'h0000FF8C);
        apb(1'b1, 12'h000, 32'h0000023F, rd, er);
        apb(1'b0, 12'h000, '0, rd, er);
        chk(rd, 32'h0000023F);
        core.levels(1'b1, 1'b1, 16'h0100);
        repeat (3) @(negedge i_sys_clk);
        chk({27'h0, o_mode}, 32'h0000001F);
        chk({31'h0, o_ram_overlay_hit}, 32'h1);
        chk({16'h0, o_ext_address}, 32'h00000100);
        chk({31'h0, o_clock_output_pin}, 32'h1);
        core.levels(1'b0, 1'b1, 16'h0040);
        repeat (3) @(negedge i_sys_clk);
        chk({27'h0, o_mode}, 32'h0000001D);
        chk({31'h0, o_ram_overlay_hit}, 32'h0);
        for (int i = 0; i < 32; i++) begin
            core.take(1'b0, i[4:0]);
            @(negedge i_sys_clk);
            chk({16'h0, o_program_counter}, {16'h0, 9'h004, i[4:0], 2'b00});
        end
        core.take(1'b1, 5'd0);
        apb(1'b0, 12'h004, '0, rd, er);
        chk(rd, 32'h0000FF80);
        core.soft_reset();
        apb(1'b0, 12'h000, '0, rd, er);
        chk(rd, 32'h00000200);
        @(negedge i_sys_clk);
        er = o_clock_output_pin;
        @(negedge i_sys_clk);
        chk({31'h0, o_clock_output_pin}, {31'h0, ~er});
        core.ext(16'h5A5A);
        core.levels(1'b0, 1'b0, 16'h1111);
        repeat (2) @(negedge i_sys_clk);
        chk({16'h0, o_ext_address}, 32'h00005A5A);
        apb(1'b0, PMS_OFS_EXT_ADDRESS, '0, rd, er);
        chk(rd, 32'h00005A5A);
        apb(1'b0, 12'h00C, '0, rd, er);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b1, 12'h000, 32'h00000040, rd, er);
        repeat (2) @(negedge i_sys_clk);
        chk({27'h0, o_mode}, 32'h0);
        core.soft_reset();
        apb(1'b0, PMS_OFS_MODE_STATUS, '0, rd, er);
        chk(rd, 32'h00000040);
        wrap_up();
    end
endmodule : test_processor_mode_status_vectors
